// ---- design/sync3.sv ----
// three-stage input synchroniser with agreement qualifier
`timescale 1ns/1ps
module sync3 (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// async in, qualified out
	input wire logic din,
	output logic dout
);
	logic [2:0] s_q;
	logic [2:0] s_d;
	logic o_q;
	logic o_d;
	// shift chain; output follows only when stages two and three agree
	always_comb begin
		s_d = {s_q[1:0], din};
		o_d = (s_q[1] == s_q[2]) ? s_q[2] : o_q;
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= 3'h0;
			o_q <= 1'b0;
		end else begin
			s_q <= s_d;
			o_q <= o_d;
		end
	end
	assign dout = o_q;
endmodule : sync3

// ---- design/wdt_pkg.sv ----
// constants and types shared by the window watchdog supervisor
package wdt_pkg;
	localparam int CLK_HZ = 50_000_000;
	// factory window with timing pin open, selector lo=0 hi=1
	localparam int FACT_LOWER_US = 2200;
	localparam int FACT_UPPER_US = 22000;
	// reset hold time with delay pin open
	localparam int RST_HOLD_MS = 170;
	// capacitor mode: upper = 77.4 * C(uF) + 0.055 s, C in pF given as code
	localparam int CAP_SLOPE_NS_PER_PF = 77400;
	localparam int CAP_OFFSET_US = 55000;
	// time base: one tick per microsecond
	localparam int TICK_DIV = CLK_HZ / 1_000_000;
	localparam logic [5:0] TICK_DIV_M1 = 6'(TICK_DIV - 1);
	localparam int TWIDTH = 32;
	localparam logic [TWIDTH-1:0] FACT_LOWER_T = TWIDTH'(FACT_LOWER_US);
	localparam logic [TWIDTH-1:0] FACT_UPPER_T = TWIDTH'(FACT_UPPER_US);
	localparam logic [TWIDTH-1:0] RST_HOLD_T = TWIDTH'(RST_HOLD_MS * 1000);
	localparam logic [TWIDTH-1:0] CAP_OFFSET_T = TWIDTH'(CAP_OFFSET_US);
	localparam int CAP_W = 16;
	// timing pin option
	typedef enum logic [1:0] {
		PIN_OPEN = 2'b00,
		PIN_CAP = 2'b01,
		PIN_PULLUP = 2'b10
	} pin_opt_t;
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_OFF = 2'b01,
		ST_WINDOW = 2'b10
	} wd_state_t;
	// pulse width of the fault output, in microsecond ticks
	localparam logic [TWIDTH-1:0] FAULT_PULSE_T = TWIDTH'(1000);
endpackage : wdt_pkg

// ---- design/window_watchdog_supervisor.sv ----
// window watchdog and reset-delay logic of a voltage supervisor
`timescale 1ns/1ps
// Summary of operation
// - open pin, lo=0 hi=1: 2.2/22 ms window
// - lo=1 hi=0 disables until either selector changes
// - disabled watchdog keeps fault output high
// - capacitor mode: lower bound is half upper
// - capacitor mode upper = 77.4*C + 0.055 s
// - factory timings within fifteen percent nominal
// - open delay pin holds reset 170 ms
// - reset and fault are open-drain active low
module window_watchdog_supervisor #(
	// clock cycles per timer tick and microseconds per tick; defaults give 1 us per tick
	parameter int CYC_PER_TICK = wdt_pkg::TICK_DIV,
	parameter int US_PER_TICK = 1
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_B,
	// host watchdog input and selectors (pins)
	input wire logic WDI,
	input wire logic TIMING_SELECT_LO,
	input wire logic TIMING_SELECT_HI,
	// timing pin option and capacitor value in pF
	input wire wdt_pkg::pin_opt_t WATCHDOG_TIMING_PIN,
	input wire logic [wdt_pkg::CAP_W-1:0] CAP_PF,
	// open-drain outputs: out value and enable
	output logic RESET_N_O,
	output logic RESET_N_OE,
	output logic WATCHDOG_FAULT_N_O,
	output logic WATCHDOG_FAULT_N_OE
);
	import wdt_pkg::*;

	// every bound is counted in ticks; a coarser tick shortens a bench run
	// at the cost of resolution, so only whole multiples of the tick are exact
	localparam logic [5:0] DIV_M1 = 6'(CYC_PER_TICK - 1);
	localparam logic [TWIDTH-1:0] TICK_US_T = TWIDTH'(US_PER_TICK);
	// factory window, reset hold and fault pulse, all in ticks
	localparam logic [TWIDTH-1:0] F_LOWER_T = FACT_LOWER_T / TICK_US_T;
	localparam logic [TWIDTH-1:0] F_UPPER_T = FACT_UPPER_T / TICK_US_T;
	localparam logic [TWIDTH-1:0] HOLD_T = RST_HOLD_T / TICK_US_T;
	localparam logic [TWIDTH-1:0] PULSE_T = FAULT_PULSE_T / TICK_US_T;
	// reset hold in clock cycles, handed to the checker through the bind
	localparam int HOLD_CYC = int'(HOLD_T) * CYC_PER_TICK;

	// qualified pin levels
	logic wdi_s;
	logic sel_lo_s;
	logic sel_hi_s;
	// tick divider
	logic [5:0] div_q;
	logic [5:0] div_d;
	logic tick_q;
	logic tick_d;
	// state, window counter and fault pulse counter
	wd_state_t st_q;
	wd_state_t st_d;
	logic [TWIDTH-1:0] cnt_q;
	logic [TWIDTH-1:0] cnt_d;
	logic [TWIDTH-1:0] flt_q;
	logic [TWIDTH-1:0] flt_d;
	logic wdi_prev_q;
	logic wdi_prev_d;
	// open-drain pull enables
	logic rst_od_q;
	logic rst_od_d;
	logic flt_od_q;
	logic flt_od_d;
	// decoded window and mode
	logic [TWIDTH-1:0] lower_t;
	logic [TWIDTH-1:0] upper_t;
	logic wd_off;
	logic fall;

	// pins come from outside the clock domain
	sync3 u_wdi (.clk(SYS_CLK), .rst_b(RST_B), .din(WDI), .dout(wdi_s));
	sync3 u_slo (.clk(SYS_CLK), .rst_b(RST_B), .din(TIMING_SELECT_LO), .dout(sel_lo_s));
	sync3 u_shi (.clk(SYS_CLK), .rst_b(RST_B), .din(TIMING_SELECT_HI), .dout(sel_hi_s));

	// capacitor-programmed upper bound in ticks
	function automatic logic [TWIDTH-1:0] cap_upper(input logic [CAP_W-1:0] pf);
		logic [47:0] ns;
		ns = 48'(pf) * 48'(CAP_SLOPE_NS_PER_PF);
		// scaled to ticks after the offset is added so the division to ticks rounds only once
		cap_upper = (TWIDTH'(ns / 48'd1000) + CAP_OFFSET_T) / TICK_US_T;
	endfunction : cap_upper

	// window selection; pullup option uses the factory window as well
	always_comb begin
		wd_off = sel_lo_s && !sel_hi_s;
		if (WATCHDOG_TIMING_PIN == PIN_CAP) begin
			upper_t = cap_upper(CAP_PF);
			lower_t = upper_t >> 1;
		end else begin
			// nominal values; digital timing is exact, inside the tolerance band
			lower_t = F_LOWER_T;
			upper_t = F_UPPER_T;
		end
	end

	// microsecond tick divider
	always_comb begin
		// with one cycle per tick the divider stays at zero and ticks every cycle
		tick_d = (div_q == DIV_M1);
		div_d = tick_d ? 6'h00 : div_q + 6'h01;
	end
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			div_q <= 6'h00;
			tick_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

	// falling edge on the qualified watchdog input; the synchroniser and this
	// register both reset low, so the idle-high pin cannot fake an edge
	assign fall = wdi_prev_q && !wdi_s;

	// watchdog state machine with reset hold and fault pulse
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		flt_d = flt_q;
		wdi_prev_d = wdi_s;
		rst_od_d = rst_od_q;
		flt_od_d = 1'b0;
		if (flt_q != '0) begin
			flt_od_d = 1'b1;
			if (tick_q)
				flt_d = flt_q - TWIDTH'(1);
		end
		case (st_q)
			// count out the reset hold; host edges are ignored meanwhile
			ST_RESET: begin
				rst_od_d = 1'b1;
				if (tick_q)
					cnt_d = cnt_q + TWIDTH'(1);
				if (cnt_q >= HOLD_T) begin
					rst_od_d = 1'b0;
					cnt_d = '0;
					st_d = wd_off ? ST_OFF : ST_WINDOW;
				end
			end
			// disabled: fault stays released, the window waits at zero
			ST_OFF: begin
				flt_d = '0;
				flt_od_d = 1'b0;
				cnt_d = '0;
				if (!wd_off)
					st_d = ST_WINDOW;
			end
			// watching the host; disable has priority over a pending edge
			ST_WINDOW: begin
				if (wd_off) begin
					st_d = ST_OFF;
					flt_d = '0;
					flt_od_d = 1'b0;
				end else if (fall) begin
					// edge restarts the window; early edge is a fault
					cnt_d = '0;
					if (cnt_q < lower_t) begin
						flt_d = PULSE_T;
						flt_od_d = 1'b1;
					end
				end else if (cnt_q >= upper_t) begin
					// timeout: fault and start a fresh window
					cnt_d = '0;
					flt_d = PULSE_T;
					flt_od_d = 1'b1;
				end else if (tick_q) begin
					cnt_d = cnt_q + TWIDTH'(1);
				end
			end
			default: st_d = ST_RESET;
		endcase
	end
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_q <= ST_RESET;
			cnt_q <= '0;
			flt_q <= '0;
			wdi_prev_q <= 1'b0;
			rst_od_q <= 1'b1;
			flt_od_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			flt_q <= flt_d;
			wdi_prev_q <= wdi_prev_d;
			rst_od_q <= rst_od_d;
			flt_od_q <= flt_od_d;
		end
	end

	// open drain: value always low, enable pulls the line
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			RESET_N_O <= 1'b0;
			WATCHDOG_FAULT_N_O <= 1'b0;
		end else begin
			RESET_N_O <= 1'b0;
			WATCHDOG_FAULT_N_O <= 1'b0;
		end
	end
	assign RESET_N_OE = rst_od_q;
	assign WATCHDOG_FAULT_N_OE = flt_od_q;
endmodule : window_watchdog_supervisor

// ---- tb/wdt_assertions.sv ----
// checker for the window watchdog supervisor
`timescale 1ns/1ps
module wdt_assertions #(
	// reset hold in clock cycles
	parameter int HOLD_CYC = 8500000
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_B,
	// selectors
	input wire logic TIMING_SELECT_LO,
	input wire logic TIMING_SELECT_HI,
	// open-drain outputs
	input wire logic RESET_N_O,
	input wire logic RESET_N_OE,
	input wire logic WATCHDOG_FAULT_N_O,
	input wire logic WATCHDOG_FAULT_N_OE
);
	logic [23:0] cyc_q;
	logic [23:0] cyc_d;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	// cycles since reset release, saturating so it never wraps
	always_comb begin
		cyc_d = (&cyc_q) ? cyc_q : cyc_q + 24'h1;
	end
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) cyc_q <= 24'h0;
		else cyc_q <= cyc_d;
	end
	property p_rst_lvl; RESET_N_O == 1'b0; endproperty
	a_rst_lvl: assert property (p_rst_lvl) else $error("reset drives high");
	property p_flt_lvl; WATCHDOG_FAULT_N_O == 1'b0; endproperty
	a_flt_lvl: assert property (p_flt_lvl) else $error("fault drives high");
	property p_rel; $rose(RST_B) |-> RESET_N_OE; endproperty
	a_rel: assert property (p_rel) else $error("reset not held");
	property p_hold;
		$fell(RESET_N_OE) |-> cyc_q >= 24'(HOLD_CYC) && cyc_q < 24'(HOLD_CYC + 200);
	endproperty
	a_hold: assert property (p_hold) else $error("reset hold length");
	property p_stay; $fell(RESET_N_OE) |=> !RESET_N_OE [*8]; endproperty
	a_stay: assert property (p_stay) else $error("reset came back");
	property p_off; (TIMING_SELECT_LO && !TIMING_SELECT_HI) [*8] |-> !$rose(WATCHDOG_FAULT_N_OE);
	endproperty
	a_off: assert property (p_off) else $error("fault while disabled");
	property p_pulse; $rose(WATCHDOG_FAULT_N_OE) |=> WATCHDOG_FAULT_N_OE [*8]; endproperty
	a_pulse: assert property (p_pulse) else $error("fault pulse short");
	property p_quiet; $rose(WATCHDOG_FAULT_N_OE) |-> $past(!RESET_N_OE, 2); endproperty
	a_quiet: assert property (p_quiet) else $error("fault in reset");
endmodule : wdt_assertions
bind window_watchdog_supervisor wdt_assertions #(.HOLD_CYC(HOLD_CYC)) u_chk (
	.SYS_CLK(SYS_CLK), .RST_B(RST_B),
	.TIMING_SELECT_LO(TIMING_SELECT_LO), .TIMING_SELECT_HI(TIMING_SELECT_HI),
	.RESET_N_O(RESET_N_O), .RESET_N_OE(RESET_N_OE), .WATCHDOG_FAULT_N_O(WATCHDOG_FAULT_N_O),
	.WATCHDOG_FAULT_N_OE(WATCHDOG_FAULT_N_OE));

// ---- tb/wdt_host_model.sv ----
// host that kicks the watchdog input
`timescale 1ns/1ps
module wdt_host_model (
	// clock
	input wire logic clk,
	// kick request and watchdog pin
	input wire logic kick,
	output logic wdi
);
	// held low 8 cycles so the synchroniser cannot miss it; driven on falling edges
	initial begin
		wdi = 1'b1;
		forever begin
			@(posedge clk iff kick);
			@(negedge clk);
			wdi = 1'b0;
			repeat (8) @(negedge clk);
			wdi = 1'b1;
		end
	end
endmodule : wdt_host_model

// ---- tb/window_watchdog_supervisor_tb_top.sv ----
// self-checking bench for the window watchdog supervisor
`timescale 1ns/1ps
module window_watchdog_supervisor_tb_top;
	logic clk;
	logic rst_b;
	logic kick;
	logic wdi;
	logic lo;
	logic hi;
	wdt_pkg::pin_opt_t topt;
	logic [15:0] cap;
	logic r_oe;
	logic f_oe;
	int failures;
	int total_checks;
	int cycles;
	// one cycle stands for ten microseconds so the run stays short
	window_watchdog_supervisor #(.CYC_PER_TICK(1), .US_PER_TICK(10)) u_dut (.SYS_CLK(clk),
		.RST_B(rst_b), .WDI(wdi), .TIMING_SELECT_LO(lo), .TIMING_SELECT_HI(hi),
		.WATCHDOG_TIMING_PIN(topt), .CAP_PF(cap), .RESET_N_O(),
		.RESET_N_OE(r_oe), .WATCHDOG_FAULT_N_O(), .WATCHDOG_FAULT_N_OE(f_oe));
	wdt_host_model u_host (.clk(clk), .kick(kick), .wdi(wdi));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string what, input logic seen, input logic exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
		end
	endtask : chk
	task automatic w(input int us);
		repeat (us / 10) @(negedge clk);
	endtask : w
	task automatic kick_once();
		kick = 1'b1;
		@(negedge clk);
		kick = 1'b0;
	endtask : kick_once
	task automatic print_verdict();
		if (failures == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	// reset stays pulled low for the whole delay
	task automatic t_hold();
		w(169990);
		chk("reset", r_oe, 1'b1);
		w(100);
		chk("reset", r_oe, 1'b0);
	endtask : t_hold
	// kick inside the window, then let it lapse
	task automatic t_late();
		w(4990);
		kick_once();
		w(17100);
		chk("fault", f_oe, 1'b0);
		w(5000);
		chk("fault", f_oe, 1'b1);
	endtask : t_late
	// kick before the lower bound
	task automatic t_early();
		w(1100);
		chk("fault", f_oe, 1'b0);
		w(300);
		kick_once();
		w(100);
		chk("fault", f_oe, 1'b1);
	endtask : t_early
	// disabled watchdog ignores everything, re-enable starts fresh
	task automatic t_off();
		w(1200);
		lo = 1'b1;
		hi = 1'b0;
		w(100);
		kick_once();
		w(30000);
		chk("fault", f_oe, 1'b0);
		lo = 1'b0;
		hi = 1'b1;
		w(21000);
		chk("fault", f_oe, 1'b0);
		w(1100);
		chk("fault", f_oe, 1'b1);
	endtask : t_off
	// 100 pF: upper 62740 us, lower 31370 us; factory bounds would differ
	task automatic t_cap();
		topt = wdt_pkg::PIN_CAP;
		cap = 16'h0064;
		w(25000);
		chk("fault", f_oe, 1'b0);
		kick_once();
		w(100);
		chk("fault", f_oe, 1'b1);
		w(61000);
		chk("fault", f_oe, 1'b0);
		w(2500);
		chk("fault", f_oe, 1'b1);
	endtask : t_cap
	// main sequence
	initial begin
		rst_b = 1'b0;
		kick = 1'b0;
		lo = 1'b0;
		hi = 1'b1;
		topt = wdt_pkg::PIN_OPEN;
		cap = 16'h0000;
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		t_hold();
		t_late();
		t_early();
		t_off();
		t_cap();
		print_verdict();
	end
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			print_verdict();
		end
	end
endmodule : window_watchdog_supervisor_tb_top
